// ### verilog/potential_loss_pkg.sv
// Constants shared by the potential-loss watch and its rotation checkers.
// Measured magnitudes arrive as unsigned per-unit words where PU_ONE is rated value.
package potential_loss_pkg;
    localparam int MAG_W = 16;
    localparam int ELEM_N = 8;
    localparam int ROT_N = 2;
    localparam logic [MAG_W-1:0] PU_ONE = 16'h1000;
    localparam logic [MAG_W-1:0] LVL_HUNDREDTH = MAG_W'(PU_ONE / 100);
    localparam logic [MAG_W-1:0] LVL_TENTH = MAG_W'(PU_ONE / 10);
    localparam int RATIO_NUM = 4;
    localparam int RATIO_DEN = 10;
    localparam int CLK_PERIOD_NS = 50;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_LOAD_THR = 8'h08;
    localparam logic [7:0] ADDR_OC_MASK = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FUSE_CLR = 8'h14;
    localparam int CTRL_PERMIT = 0;
    localparam int CTRL_REVERSING = 1;
    localparam int CTRL_ROT_ACB = 2;
    localparam int CTRL_BRK_ASSIGNED = 3;
    localparam int ST_BLOCK = 0;
    localparam int ST_COND = 1;
    localparam int ST_FUSE = 2;
    localparam int ST_ROT = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] DELAY_RESET = 16'h0064;
    localparam logic [15:0] LOAD_THR_RESET = 16'h0200;
    localparam logic [7:0] OC_MASK_RESET = 8'h00;
endpackage

// ### verilog/rotation_check.sv
// Phase-rotation checker for one measuring input.
// Assumes sequence magnitudes and input level are in the shared per-unit scale.
`timescale 1ns/100ps
`default_nettype none
module rotation_check
    import potential_loss_pkg::*;
(
    input wire logic i_clk_sys, // System clock.
    input wire logic i_rst_b, // Asynchronous reset, active low.
    input wire logic [MAG_W-1:0] i_pos, // Positive-sequence magnitude.
    input wire logic [MAG_W-1:0] i_neg, // Negative-sequence magnitude.
    input wire logic [MAG_W-1:0] i_level, // Input magnitude.
    input wire logic i_setting_acb, // Configured rotation is reversed.
    input wire logic i_reversing, // Both rotations allowed.
    output logic o_warn // Rotation differs from setting.
);
    logic measured_acb;
    logic level_ok;

    // A dominant negative sequence means the inputs see the reversed rotation.
    assign measured_acb = i_neg > i_pos;
    assign level_ok = i_level >= LVL_TENTH;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_warn <= 1'b0;
        end else if (!level_ok || i_reversing) begin
            o_warn <= 1'b0;
        end else begin
            o_warn <= measured_acb != i_setting_acb;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    property p_rot_compare;
        level_ok && !i_reversing |=> o_warn == $past(measured_acb != i_setting_acb);
    endproperty
    a_rot_compare: assert property (p_rot_compare) else $error("rotation warning wrong");
    property p_rot_reversing;
        i_reversing |=> !o_warn;
    endproperty
    a_rot_reversing: assert property (p_rot_reversing) else $error("warning while reversing");
    property p_rot_low;
        !level_ok |=> !o_warn;
    endproperty
    a_rot_low: assert property (p_rot_low) else $error("warning at low level");
    c_rot_warn: cover property (!o_warn ##1 o_warn);
endmodule
`default_nettype wire

// ### verilog/potential_loss_watch.sv
// Potential-loss supervision with fuse-input watch and per-input rotation checks.
// Assumes all inputs synchronous to i_clk_sys and a single-cycle register port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Block only when all measured, pickup, breaker and dead-bus conditions hold.
// - Some phase voltage must be below one hundredth of rated.
// - Residual voltage below one hundredth, or negative/positive ratio above forty percent.
// - All three phase currents below the load-current threshold.
// - Residual current below one tenth of rated current.
// - No assigned overcurrent element picked up.
// - Breaker closed when assigned; ignored when unassigned.
// - No block while a dead busbar is reported.
// - Active block inhibits elements whose supervision enable is set.
// - A fuse-input change blocks all supervised elements.
// - Rotation derived from sequence components and compared with setting.
// - One rotation warning flag per measuring input.
// - Reversing permission suppresses every rotation warning.
// - Voltage rotation checked only at one tenth rated voltage or more.
// - Current rotation checked only at one tenth rated current or more.
// - Block issued only after conditions persist for the alarm delay.
// - Block reaches elements only while the block permit is set.
module potential_loss_watch
    import potential_loss_pkg::*;
#(
    parameter int P_UNIT_CYCLES = DELAY_UNIT_CYC
) (
    input wire logic i_clk_sys, // System clock, 20 MHz.
    input wire logic i_rst_b, // Asynchronous reset, active low.
    input wire logic [7:0] i_addr, // Register byte address.
    input wire logic [31:0] i_wr_data, // Register write data.
    input wire logic i_wr_en, // Write strobe.
    input wire logic i_rd_en, // Read strobe.
    output logic [31:0] o_rd_data, // Read data, cycle after strobe.
    input wire logic [MAG_W-1:0] i_v_ph1, // Phase 1 voltage.
    input wire logic [MAG_W-1:0] i_v_ph2, // Phase 2 voltage.
    input wire logic [MAG_W-1:0] i_v_ph3, // Phase 3 voltage.
    input wire logic [MAG_W-1:0] i_v_res, // Residual voltage.
    input wire logic [MAG_W-1:0] i_v_pos, // Positive-sequence voltage.
    input wire logic [MAG_W-1:0] i_v_neg, // Negative-sequence voltage.
    input wire logic [MAG_W-1:0] i_i_ph1, // Phase 1 current.
    input wire logic [MAG_W-1:0] i_i_ph2, // Phase 2 current.
    input wire logic [MAG_W-1:0] i_i_ph3, // Phase 3 current.
    input wire logic [MAG_W-1:0] i_i_res, // Residual current.
    input wire logic [MAG_W-1:0] i_i_pos, // Positive-sequence current.
    input wire logic [MAG_W-1:0] i_i_neg, // Negative-sequence current.
    input wire logic [MAG_W-1:0] i_i_level, // Current level for rotation check.
    input wire logic [MAG_W-1:0] i_v_level, // Voltage level for rotation check.
    input wire logic [ELEM_N-1:0] i_oc_pickup, // Overcurrent pickups.
    input wire logic i_breaker_closed, // Breaker closed.
    input wire logic i_dead_bus, // Offline detection: dead busbar.
    input wire logic i_fuse_trip_input, // VT automatic breaker state.
    input wire logic [ELEM_N-1:0] i_mcs_enable, // Element supervision enables.
    output logic o_potential_loss_block, // Potential-loss block.
    output logic [ELEM_N-1:0] o_elem_block, // Per-element inhibit.
    output logic [ROT_N-1:0] o_rot_warn // Rotation warning, bit0 VT, bit1 CT.
);
    logic [3:0] ctrl_reg;
    logic [15:0] delay_reg;
    logic [15:0] load_thr_reg;
    logic [7:0] oc_mask_reg;
    logic [31:0] unit_cnt_reg;
    logic [15:0] ms_cnt_reg;
    logic fuse_prev_reg;
    logic fuse_primed_reg;
    logic fuse_flag_reg;
    logic any_v_low;
    logic res_ok;
    logic i_low;
    logic ires_ok;
    logic oc_ok;
    logic brk_ok;
    logic cond;
    logic fuse_change;
    logic fuse_clr;
    logic [19:0] ratio_neg;
    logic [19:0] ratio_pos;
    logic [31:0] status_word;
    logic [MAG_W-1:0] rot_pos [ROT_N];
    logic [MAG_W-1:0] rot_neg [ROT_N];
    logic [MAG_W-1:0] rot_lvl [ROT_N];
    logic [31:0] cond_run_reg;
    logic [31:0] hold_need;

    assign any_v_low = (i_v_ph1 < LVL_HUNDREDTH) || (i_v_ph2 < LVL_HUNDREDTH)
        || (i_v_ph3 < LVL_HUNDREDTH);
    assign ratio_neg = 20'(i_v_neg) * 20'(RATIO_DEN);
    assign ratio_pos = 20'(i_v_pos) * 20'(RATIO_NUM);
    assign res_ok = (i_v_res < LVL_HUNDREDTH) || (ratio_neg > ratio_pos);
    assign i_low = (i_i_ph1 < load_thr_reg) && (i_i_ph2 < load_thr_reg)
        && (i_i_ph3 < load_thr_reg);
    assign ires_ok = i_i_res < LVL_TENTH;
    assign oc_ok = ~|(i_oc_pickup & oc_mask_reg);
    assign brk_ok = !ctrl_reg[CTRL_BRK_ASSIGNED] || i_breaker_closed;
    assign cond = any_v_low && res_ok && i_low && ires_ok && oc_ok && brk_ok && !i_dead_bus;
    assign fuse_change = fuse_primed_reg && (i_fuse_trip_input != fuse_prev_reg);
    assign fuse_clr = i_wr_en && (i_addr == ADDR_FUSE_CLR) && i_wr_data[0];
    assign hold_need = 32'(delay_reg) * 32'(P_UNIT_CYCLES);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= CTRL_RESET;
            delay_reg <= DELAY_RESET;
            load_thr_reg <= LOAD_THR_RESET;
            oc_mask_reg <= OC_MASK_RESET;
        end else if (i_wr_en) begin
            unique case (i_addr)
                ADDR_CTRL: ctrl_reg <= i_wr_data[3:0];
                ADDR_DELAY: delay_reg <= i_wr_data[15:0];
                ADDR_LOAD_THR: load_thr_reg <= i_wr_data[15:0];
                ADDR_OC_MASK: oc_mask_reg <= i_wr_data[7:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[ST_BLOCK] = o_potential_loss_block;
        status_word[ST_COND] = cond;
        status_word[ST_FUSE] = fuse_flag_reg;
        status_word[ST_ROT +: ROT_N] = o_rot_warn;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= 32'h0;
        end else if (i_rd_en) begin
            unique case (i_addr)
                ADDR_CTRL: o_rd_data <= {28'h0, ctrl_reg};
                ADDR_DELAY: o_rd_data <= {16'h0, delay_reg};
                ADDR_LOAD_THR: o_rd_data <= {16'h0, load_thr_reg};
                ADDR_OC_MASK: o_rd_data <= {24'h0, oc_mask_reg};
                ADDR_STATUS: o_rd_data <= status_word;
                default: o_rd_data <= 32'h0;
            endcase
        end else begin
            o_rd_data <= 32'h0;
        end
    end

    // Delay counts whole milliseconds; any break in the conditions restarts it.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            unit_cnt_reg <= 32'h0;
            ms_cnt_reg <= 16'h0;
            o_potential_loss_block <= 1'b0;
        end else if (!cond) begin
            unit_cnt_reg <= 32'h0;
            ms_cnt_reg <= 16'h0;
            o_potential_loss_block <= 1'b0;
        end else if (ms_cnt_reg >= delay_reg) begin
            o_potential_loss_block <= 1'b1;
        end else if (unit_cnt_reg >= 32'(P_UNIT_CYCLES - 1)) begin
            unit_cnt_reg <= 32'h0;
            ms_cnt_reg <= ms_cnt_reg + 16'h1;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 32'h1;
        end
    end

    // Counts edges with the conditions held, so the delay can be checked apart from the unit counters.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cond_run_reg <= 32'h0;
        end else if (!cond) begin
            cond_run_reg <= 32'h0;
        end else if (~&cond_run_reg) begin
            cond_run_reg <= cond_run_reg + 32'h1;
        end
    end

    // The first sample after reset only primes the edge detector.
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fuse_prev_reg <= 1'b0;
            fuse_primed_reg <= 1'b0;
            fuse_flag_reg <= 1'b0;
        end else begin
            fuse_prev_reg <= i_fuse_trip_input;
            fuse_primed_reg <= 1'b1;
            if (fuse_change) begin
                fuse_flag_reg <= 1'b1;
            end else if (fuse_clr) begin
                fuse_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_elem_block <= '0;
        end else begin
            o_elem_block <= i_mcs_enable & {ELEM_N{(o_potential_loss_block && ctrl_reg[CTRL_PERMIT])
                || fuse_flag_reg}};
        end
    end

    assign rot_pos[0] = i_v_pos;
    assign rot_neg[0] = i_v_neg;
    assign rot_lvl[0] = i_v_level;
    assign rot_pos[1] = i_i_pos;
    assign rot_neg[1] = i_i_neg;
    assign rot_lvl[1] = i_i_level;

    for (genvar g = 0; g < ROT_N; g++) begin : g_rot
        rotation_check u_rot (
            .i_clk_sys(i_clk_sys),
            .i_rst_b(i_rst_b),
            .i_pos(rot_pos[g]),
            .i_neg(rot_neg[g]),
            .i_level(rot_lvl[g]),
            .i_setting_acb(ctrl_reg[CTRL_ROT_ACB]),
            .i_reversing(ctrl_reg[CTRL_REVERSING]),
            .o_warn(o_rot_warn[g])
        );
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    property p_block_cond;
        o_potential_loss_block |-> $past(cond);
    endproperty
    a_block_cond: assert property (p_block_cond) else $error("block without conditions");
    property p_volt_high;
        !any_v_low |=> !o_potential_loss_block;
    endproperty
    a_volt_high: assert property (p_volt_high) else $error("block with healthy voltages");
    property p_res_volt;
        !res_ok |=> !o_potential_loss_block;
    endproperty
    a_res_volt: assert property (p_res_volt) else $error("block with residual voltage");
    property p_load;
        !i_low |=> !o_potential_loss_block;
    endproperty
    a_load: assert property (p_load) else $error("block under load current");
    property p_res_cur;
        (i_i_res >= LVL_TENTH) |=> !o_potential_loss_block;
    endproperty
    a_res_cur: assert property (p_res_cur) else $error("block with residual current");
    property p_oc;
        |(i_oc_pickup & oc_mask_reg) |=> !o_potential_loss_block;
    endproperty
    a_oc: assert property (p_oc) else $error("block during overcurrent pickup");
    property p_brk;
        ctrl_reg[CTRL_BRK_ASSIGNED] && !i_breaker_closed |=> !o_potential_loss_block;
    endproperty
    a_brk: assert property (p_brk) else $error("block with breaker open");
    property p_dead;
        i_dead_bus |=> !o_potential_loss_block;
    endproperty
    a_dead: assert property (p_dead) else $error("block on dead busbar");
    property p_elem;
        o_potential_loss_block && ctrl_reg[CTRL_PERMIT] |=> o_elem_block == $past(i_mcs_enable);
    endproperty
    a_elem: assert property (p_elem) else $error("element inhibit wrong");
    property p_permit;
        !ctrl_reg[CTRL_PERMIT] && !fuse_flag_reg |=> o_elem_block == '0;
    endproperty
    a_permit: assert property (p_permit) else $error("inhibit without permit");
    property p_fuse;
        fuse_change |=> fuse_flag_reg ##1 (o_elem_block == $past(i_mcs_enable));
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse change not blocking");
    property p_delay;
        $rose(o_potential_loss_block) |-> $past(ms_cnt_reg >= delay_reg) && $past(cond);
    endproperty
    a_delay: assert property (p_delay) else $error("block before delay");
    property p_delay_hold;
        cond && (cond_run_reg < hold_need) |=> !o_potential_loss_block;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("block before conditions persisted");
    property p_delay_done;
        cond && (cond_run_reg >= hold_need) |=> o_potential_loss_block;
    endproperty
    a_delay_done: assert property (p_delay_done) else $error("block missing after delay");
    property p_elem_unsup;
        ##1 (o_elem_block & ~$past(i_mcs_enable)) == '0;
    endproperty
    a_elem_unsup: assert property (p_elem_unsup) else $error("unsupervised element inhibited");
    property p_elem_idle;
        !o_potential_loss_block && !fuse_flag_reg |=> o_elem_block == '0;
    endproperty
    a_elem_idle: assert property (p_elem_idle) else $error("inhibit without block");
    property p_fuse_set_wins;
        fuse_change && fuse_clr |=> fuse_flag_reg;
    endproperty
    a_fuse_set_wins: assert property (p_fuse_set_wins) else $error("fuse event lost to clear");
    property p_fuse_hold;
        fuse_flag_reg && !fuse_clr |=> fuse_flag_reg;
    endproperty
    a_fuse_hold: assert property (p_fuse_hold) else $error("fuse flag dropped");
    property p_fuse_clear;
        fuse_clr && !fuse_change |=> !fuse_flag_reg;
    endproperty
    a_fuse_clear: assert property (p_fuse_clear) else $error("fuse flag not cleared");

    c_block: cover property ($rose(o_potential_loss_block));
    c_fuse: cover property ($rose(fuse_flag_reg));
    c_elem: cover property (o_elem_block != '0 && !fuse_flag_reg);
    c_clear: cover property (fuse_flag_reg ##1 !fuse_flag_reg);
endmodule
`default_nettype wire

// ### verif/meas_source.sv
// Behavioural model of the voltage and current measuring inputs that feed the watch.
// Assumes the bench changes the scene code just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module meas_source
    import potential_loss_pkg::*;
(
    input wire logic [3:0] i_scene, // Scene picked by the bench.
    output logic [2:0][MAG_W-1:0] o_v_ph, // Phase voltages.
    output logic [MAG_W-1:0] o_v_res, // Residual voltage.
    output logic [MAG_W-1:0] o_v_pos, // Positive-sequence voltage.
    output logic [MAG_W-1:0] o_v_neg, // Negative-sequence voltage.
    output logic [MAG_W-1:0] o_v_level, // Voltage level.
    output logic [2:0][MAG_W-1:0] o_i_ph, // Phase currents.
    output logic [MAG_W-1:0] o_i_res, // Residual current.
    output logic [MAG_W-1:0] o_i_pos, // Positive-sequence current.
    output logic [MAG_W-1:0] o_i_neg, // Negative-sequence current.
    output logic [MAG_W-1:0] o_i_level // Current level.
);
    // Scenes: 0 healthy, 1 one phase lost, 2 lost with strong unbalance, 3 lost with residual voltage,
    // 4 lost under load, 5 lost with residual current at one tenth, 6 phase at one hundredth,
    // 7 reversed rotation, 8 reversed just below the check level, 9 reversed at the check level.
    function automatic logic [MAG_W-1:0] neg_of(input logic [3:0] s, input logic [MAG_W-1:0] hi);
        return (s == 4'h7) ? hi : (s == 4'h8) ? 16'h0198 : (s == 4'h9) ? 16'h0199 : 16'h0000;
    endfunction
    assign o_v_ph[0] = (i_scene inside {[4'h1:4'h5]}) ? 16'h0000 : (i_scene == 4'h6) ? LVL_HUNDREDTH : PU_ONE;
    assign o_v_ph[2:1] = {PU_ONE, PU_ONE};
    assign o_v_res = (i_scene inside {4'h2, 4'h3}) ? 16'h0800 : 16'h0000;
    assign o_v_pos = (i_scene inside {4'h2, 4'h3}) ? 16'h0800 : (i_scene == 4'h7) ? 16'h0100 :
        (i_scene > 4'h7) ? 16'h0010 : PU_ONE;
    assign o_v_neg = (i_scene == 4'h2) ? 16'h0400 : (i_scene == 4'h3) ? 16'h0200 : neg_of(i_scene, PU_ONE);
    assign o_v_level = (o_v_neg > o_v_pos) ? o_v_neg : o_v_pos;
    assign o_i_ph = {16'h0100, (i_scene == 4'h4) ? 16'h0300 : 16'h0100, 16'h0100};
    assign o_i_res = (i_scene == 4'h5) ? LVL_TENTH : 16'h0000;
    assign o_i_pos = (i_scene > 4'h7) ? 16'h0010 : 16'h0100;
    assign o_i_neg = neg_of(i_scene, 16'h0800);
    assign o_i_level = (o_i_neg > o_i_pos) ? o_i_neg : o_i_pos;
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the potential-loss watch: registers, block conditions, fuse input, rotation.
// Assumes the measuring-input model supplies the magnitudes from a scene code.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import potential_loss_pkg::*;
    localparam int UNIT = 4;
    logic clk_sys = 1'b0;
    logic rst_b, wr_en, rd_en, breaker_closed, dead_bus, fuse_in, block;
    logic [7:0] addr, oc_pickup, mcs_enable, elem_block;
    logic [31:0] wr_data, rd_data;
    logic [3:0] scene;
    logic [1:0] rot_warn;
    logic [2:0][MAG_W-1:0] v_ph, i_ph;
    logic [MAG_W-1:0] v_res, v_pos, v_neg, v_level, i_res, i_pos, i_neg, i_level;
    int error_cnt = 0;
    int samples_checked = 0;

    always #25 clk_sys = ~clk_sys;

    meas_source src (.i_scene(scene), .o_v_ph(v_ph), .o_v_res(v_res), .o_v_pos(v_pos), .o_v_neg(v_neg),
        .o_v_level(v_level), .o_i_ph(i_ph), .o_i_res(i_res), .o_i_pos(i_pos), .o_i_neg(i_neg),
        .o_i_level(i_level));

    potential_loss_watch #(.P_UNIT_CYCLES(UNIT)) dut (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .o_rd_data(rd_data), .i_v_ph1(v_ph[0]), .i_v_ph2(v_ph[1]), .i_v_ph3(v_ph[2]),
        .i_v_res(v_res), .i_v_pos(v_pos), .i_v_neg(v_neg), .i_i_ph1(i_ph[0]), .i_i_ph2(i_ph[1]),
        .i_i_ph3(i_ph[2]), .i_i_res(i_res), .i_i_pos(i_pos), .i_i_neg(i_neg), .i_i_level(i_level),
        .i_v_level(v_level), .i_oc_pickup(oc_pickup), .i_breaker_closed(breaker_closed),
        .i_dead_bus(dead_bus), .i_fuse_trip_input(fuse_in), .i_mcs_enable(mcs_enable),
        .o_potential_loss_block(block), .o_elem_block(elem_block), .o_rot_warn(rot_warn));

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp, "register read");
    endtask

    // Sets the measurements and side inputs, then checks the block once it has settled.
    task automatic apply(input logic [3:0] s, input logic [7:0] oc, input logic brk, input logic dead,
                         input logic exp);
        @(posedge clk_sys);
        scene <= s;
        oc_pickup <= oc;
        breaker_closed <= brk;
        dead_bus <= dead;
        wait_cyc(4);
        chk(32'(block), 32'(exp), "block");
    endtask

    task automatic rot(input logic [3:0] s, input logic [31:0] ctrl, input logic [1:0] exp);
        wr(ADDR_CTRL, ctrl);
        @(posedge clk_sys);
        scene <= s;
        wait_cyc(3);
        chk(32'(rot_warn), 32'(exp), "rotation warning");
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        scene = 4'h0;
        oc_pickup = 8'h00;
        breaker_closed = 1'b1;
        dead_bus = 1'b0;
        fuse_in = 1'b0;
        mcs_enable = 8'hA5;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ADDR_CTRL, 32'(CTRL_RESET));
        rd(ADDR_DELAY, 32'(DELAY_RESET));
        rd(ADDR_LOAD_THR, 32'(LOAD_THR_RESET));
        rd(ADDR_OC_MASK, 32'(OC_MASK_RESET));
        rd(ADDR_FUSE_CLR, 32'h0);
        rd(8'h20, 32'h0);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_DELAY, 32'h2);
        wr(ADDR_CTRL, 32'h9);
        wr(ADDR_OC_MASK, 32'h0F);
        @(posedge clk_sys);
        scene <= 4'h1;
        wait_cyc(5);
        chk(32'(block), 32'h0, "early block");
        wait_cyc(9);
        chk(32'(block), 32'h1, "delayed block");
        chk(32'(elem_block), 32'hA5, "element block");
        rd(ADDR_STATUS, 32'h3);
        apply(4'h0, 8'h00, 1'b1, 1'b0, 1'b0);
        wr(ADDR_DELAY, 32'h0);
        apply(4'h1, 8'h00, 1'b1, 1'b0, 1'b1);
        apply(4'h6, 8'h00, 1'b1, 1'b0, 1'b0);
        apply(4'h2, 8'h00, 1'b1, 1'b0, 1'b1);
        apply(4'h3, 8'h00, 1'b1, 1'b0, 1'b0);
        apply(4'h4, 8'h00, 1'b1, 1'b0, 1'b0);
        apply(4'h5, 8'h00, 1'b1, 1'b0, 1'b0);
        apply(4'h1, 8'h10, 1'b1, 1'b0, 1'b1);
        apply(4'h1, 8'h01, 1'b1, 1'b0, 1'b0);
        apply(4'h1, 8'h00, 1'b0, 1'b0, 1'b0);
        apply(4'h1, 8'h00, 1'b1, 1'b1, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        apply(4'h1, 8'h00, 1'b0, 1'b0, 1'b1);
        chk(32'(elem_block), 32'hA5, "permitted block");
        @(posedge clk_sys);
        mcs_enable <= 8'h3C;
        wait_cyc(2);
        chk(32'(elem_block), 32'h3C, "supervised subset");
        @(posedge clk_sys);
        mcs_enable <= 8'hA5;
        wr(ADDR_CTRL, 32'h0);
        wait_cyc(2);
        chk(32'(elem_block), 32'h00, "unpermitted block");
        apply(4'h0, 8'h00, 1'b1, 1'b0, 1'b0);
        wr(ADDR_LOAD_THR, 32'h0400);
        rd(ADDR_LOAD_THR, 32'h0400);
        apply(4'h4, 8'h00, 1'b1, 1'b0, 1'b1);
        wr(ADDR_LOAD_THR, 32'(LOAD_THR_RESET));
        apply(4'h4, 8'h00, 1'b1, 1'b0, 1'b0);
        @(posedge clk_sys);
        fuse_in <= 1'b1;
        wait_cyc(3);
        chk(32'(elem_block), 32'hA5, "fuse block");
        rd(ADDR_STATUS, 32'h4);
        wr(ADDR_FUSE_CLR, 32'h1);
        wait_cyc(2);
        chk(32'(elem_block), 32'h00, "fuse cleared");
        @(posedge clk_sys);
        fuse_in <= 1'b0;
        wait_cyc(3);
        chk(32'(elem_block), 32'hA5, "fuse falling");
        wr(ADDR_FUSE_CLR, 32'h1);
        rot(4'h7, 32'h0, 2'b11);
        rot(4'h7, 32'h4, 2'b00);
        rot(4'h0, 32'h4, 2'b01);
        rot(4'h7, 32'h2, 2'b00);
        rot(4'h8, 32'h0, 2'b00);
        rot(4'h9, 32'h0, 2'b11);
        rd(ADDR_STATUS, 32'h30);
        summarize();
    end
endmodule
`default_nettype wire
